/* rtl/mmd_consts.svh */
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH

// ***********************************************
// Address fields
// ***********************************************
`define MMD_HALF_BIT 15
`define MMD_BLK_MSB 14
`define MMD_BLK_LSB 13
`define MMD_OFS_MSB 12
`define MMD_ROM_AMSB 10
`define MMD_ROM_BASE 16'he000
`define MMD_LAST_ONCHIP_PAGE 7'h03
`define MMD_ROM_PAGE 7'h00

// ***********************************************
// Control fields and port count
// ***********************************************
`define MMD_ROM_EN_BIT 7
`define MMD_PORTS 2

`endif

/* rtl/mmd_pkg.sv */
`default_nettype none

package mmd_pkg;

	typedef enum logic [1:0] {
		MMD_SP_PROG = 2'h0,
		MMD_SP_DATA = 2'h1,
		MMD_SP_IO = 2'h2
	} mmd_space_t;

	typedef enum logic [2:0] {
		MMD_TG_NONE = 3'h0,
		MMD_TG_DUAL_ACCESS_RAM = 3'h1,
		MMD_TG_SINGLE_ACCESS_RAM = 3'h2,
		MMD_TG_SHARED = 3'h3,
		MMD_TG_ROM = 3'h4,
		MMD_TG_EXT = 3'h5
	} mmd_target_t;

	typedef struct packed {
		mmd_target_t target;
		logic [3:0] block;
		logic [12:0] offset;
		logic [2:0] ext_page;
		logic discard;
		logic undef_read;
		logic owner_b;
	} mmd_route_t;

endpackage

`default_nettype wire

/* rtl/mmd_sync2.sv */
`default_nettype none

module mmd_sync2 (
	input wire logic clk,
	input wire logic d,
	output logic q
);

	logic meta_q;

	// No reset: a strap level must pass both stages while reset is held
	always_ff @(posedge clk) begin
		meta_q <= d;
		q <= meta_q;
	end

endmodule

`default_nettype wire

/* rtl/mmd_decoder.sv */
// Functional notes
// - Private dual-access RAM: four 8K blocks, two accesses
// - Dual-access RAM in program space only with overlay
// - Private single-access RAM: four 8K blocks, one access
// - Single-access RAM off until data-RAM enable set
// - Shared program RAM, sixteen blocks, one fetch per cycle
// - Only the DMA engine writes shared RAM
// - Regions 0-1 owned by A, 2-3 by B
// - Private RAM reachable only by its own subsystem
// - Enabled boot ROM replaces one 8K shared block
// - Clearing ROM enable bit exposes E000-FFFF RAM
// - ROM enable captured from own strap at reset
// - Interface select and strap choose fetch source
// - External access proceeds only with interface select high
// - I/O space always goes external
// - Normal mode: pages above 3 external, aliasing 4-7
// - Microprocessor mode: upper pages external, alias 0-3
// - Lower program half: overlay picks RAM or external
// - Upper data half: enable picks single-access or external
// - Blocked external: write dropped, read undefined

`default_nettype none
`include "mmd_consts.svh"

module mmd_decoder #(
	parameter logic SUBSYS_B = 1'b0,
	parameter int PORTS = `MMD_PORTS
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic OVERLAY_ENABLE,
	input wire logic DATA_SRAM_ENABLE,
	input wire logic MICROPROCESSOR_MODE,
	input wire logic EXTERNAL_INTERFACE_SELECT,
	input wire logic ROM_STRAP_PIN,
	input wire logic GPIO_ROM_WR,
	input wire logic [15:0] GPIO_WDATA,
	input wire logic [PORTS-1:0] ACC_VALID,
	input wire logic [2*PORTS-1:0] ACC_SPACE,
	input wire logic [PORTS-1:0] ACC_WRITE,
	input wire logic [PORTS-1:0] ACC_DMA,
	input wire logic [16*PORTS-1:0] ACC_ADDR,
	input wire logic [7*PORTS-1:0] ACC_PAGE,
	output logic BOOT_ROM_ENABLE,
	output logic [PORTS-1:0] RT_VALID,
	output logic [3*PORTS-1:0] RT_TARGET,
	output logic [4*PORTS-1:0] RT_BLOCK,
	output logic [13*PORTS-1:0] RT_OFFSET,
	output logic [3*PORTS-1:0] RT_EXT_PAGE,
	output logic [PORTS-1:0] RT_WRITE,
	output logic [PORTS-1:0] RT_EXT_STROBE,
	output logic [PORTS-1:0] RT_DISCARD,
	output logic [PORTS-1:0] RT_UNDEF_READ,
	output logic [PORTS-1:0] RT_OWNER_B,
	output logic [PORTS-1:0] RT_STALL,
	output logic RT_SUBSYS_B
);

	// ***********************************************
	// Pin synchronisers and boot ROM enable
	// ***********************************************
	logic xio_s;
	logic strap_s;
	logic rom_en_q;
	logic rom_active;

	mmd_sync2 u_sync_xio (
		.clk(CLK),
		.d(EXTERNAL_INTERFACE_SELECT),
		.q(xio_s)
	);

	mmd_sync2 u_sync_strap (
		.clk(CLK),
		.d(ROM_STRAP_PIN),
		.q(strap_s)
	);

	// Strap is sampled by a clocked process while reset is held
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rom_en_q <= strap_s;
		end else if (GPIO_ROM_WR) begin
			rom_en_q <= GPIO_WDATA[`MMD_ROM_EN_BIT];
		end
	end

	assign rom_active = rom_en_q & xio_s;
	assign BOOT_ROM_ENABLE = rom_en_q;
	// Private RAM instances are selected by the decoder's own subsystem
	assign RT_SUBSYS_B = SUBSYS_B;

	// ***********************************************
	// Address decode
	// ***********************************************
	function automatic mmd_pkg::mmd_route_t route_one(input logic [1:0] space, input logic wr,
		input logic dma, input logic [15:0] a, input logic [6:0] pg);
		mmd_pkg::mmd_route_t r;
		logic hi;
		logic far_page;
		r.target = mmd_pkg::MMD_TG_NONE;
		r.block = {2'h0, a[`MMD_BLK_MSB:`MMD_BLK_LSB]};
		r.offset = a[`MMD_OFS_MSB:0];
		r.discard = 1'b0;
		r.undef_read = 1'b0;
		r.owner_b = 1'b0;
		hi = a[`MMD_HALF_BIT];
		far_page = pg > `MMD_LAST_ONCHIP_PAGE;
		if (MICROPROCESSOR_MODE) begin
			r.ext_page = {1'b0, pg[1:0]};
		end else if (far_page) begin
			r.ext_page = {1'b1, pg[1:0]};
		end else begin
			r.ext_page = pg[2:0];
		end
		unique case (space)
			mmd_pkg::MMD_SP_PROG: begin
				if (!hi) begin
					r.target = OVERLAY_ENABLE ? mmd_pkg::MMD_TG_DUAL_ACCESS_RAM : mmd_pkg::MMD_TG_EXT;
				end else if (MICROPROCESSOR_MODE || far_page) begin
					r.target = mmd_pkg::MMD_TG_EXT;
				end else if (rom_active && pg == `MMD_ROM_PAGE && a >= `MMD_ROM_BASE) begin
					r.target = mmd_pkg::MMD_TG_ROM;
					r.offset = {2'h0, a[`MMD_ROM_AMSB:0]};
					r.discard = wr;
				end else begin
					r.target = mmd_pkg::MMD_TG_SHARED;
					r.block = {pg[1:0], a[`MMD_BLK_MSB:`MMD_BLK_LSB]};
					r.owner_b = pg[1];
					r.discard = wr & ~dma;
				end
			end
			mmd_pkg::MMD_SP_DATA: begin
				if (!hi) begin
					r.target = mmd_pkg::MMD_TG_DUAL_ACCESS_RAM;
				end else begin
					r.target = DATA_SRAM_ENABLE ? mmd_pkg::MMD_TG_SINGLE_ACCESS_RAM : mmd_pkg::MMD_TG_EXT;
				end
			end
			mmd_pkg::MMD_SP_IO: begin
				r.target = mmd_pkg::MMD_TG_EXT;
			end
			default: begin
				r.target = mmd_pkg::MMD_TG_NONE;
			end
		endcase
		if (r.target == mmd_pkg::MMD_TG_EXT && !xio_s) begin
			r.discard = wr;
			r.undef_read = ~wr;
		end
		return r;
	endfunction

	mmd_pkg::mmd_route_t rt_d [PORTS];
	logic [PORTS-1:0] stall_d;

	always_comb begin
		for (int p = 0; p < PORTS; p++) begin
			rt_d[p] = route_one(ACC_SPACE[2*p +: 2], ACC_WRITE[p], ACC_DMA[p],
				ACC_ADDR[16*p +: 16], ACC_PAGE[7*p +: 7]);
		end
	end

	// A later port yields when an earlier one holds the same single-ported
	// resource: a single-access block, or this subsystem's shared fetch slot
	always_comb begin
		stall_d = '0;
		for (int p = 1; p < PORTS; p++) begin
			for (int e = 0; e < p; e++) begin
				if (ACC_VALID[p] && ACC_VALID[e] && !stall_d[e]) begin
					if (rt_d[p].target == mmd_pkg::MMD_TG_SINGLE_ACCESS_RAM && rt_d[e].target == mmd_pkg::MMD_TG_SINGLE_ACCESS_RAM
						&& rt_d[p].block == rt_d[e].block) begin
						stall_d[p] = 1'b1;
					end
					if (rt_d[p].target == mmd_pkg::MMD_TG_SHARED && rt_d[e].target == mmd_pkg::MMD_TG_SHARED) begin
						stall_d[p] = 1'b1;
					end
				end
			end
		end
	end

	// ***********************************************
	// Registered routing outputs
	// ***********************************************
	for (genvar p = 0; p < PORTS; p++) begin : g_port
		logic go;
		assign go = ACC_VALID[p] & ~stall_d[p];

		always_ff @(posedge CLK) begin
			if (SYS_RST) begin
				RT_VALID[p] <= 1'b0;
				RT_TARGET[3*p +: 3] <= mmd_pkg::MMD_TG_NONE;
				RT_BLOCK[4*p +: 4] <= 4'h0;
				RT_OFFSET[13*p +: 13] <= 13'h0000;
				RT_EXT_PAGE[3*p +: 3] <= 3'h0;
				RT_OWNER_B[p] <= 1'b0;
			end else begin
				RT_VALID[p] <= go;
				RT_TARGET[3*p +: 3] <= go ? rt_d[p].target : mmd_pkg::MMD_TG_NONE;
				RT_BLOCK[4*p +: 4] <= rt_d[p].block;
				RT_OFFSET[13*p +: 13] <= rt_d[p].offset;
				RT_EXT_PAGE[3*p +: 3] <= rt_d[p].ext_page;
				RT_OWNER_B[p] <= rt_d[p].owner_b;
			end
		end

		always_ff @(posedge CLK) begin
			if (SYS_RST) begin
				RT_WRITE[p] <= 1'b0;
				RT_EXT_STROBE[p] <= 1'b0;
				RT_DISCARD[p] <= 1'b0;
				RT_UNDEF_READ[p] <= 1'b0;
				RT_STALL[p] <= 1'b0;
			end else begin
				RT_WRITE[p] <= go & ACC_WRITE[p] & ~rt_d[p].discard;
				RT_EXT_STROBE[p] <= go & (rt_d[p].target == mmd_pkg::MMD_TG_EXT) & xio_s;
				RT_DISCARD[p] <= go & rt_d[p].discard;
				RT_UNDEF_READ[p] <= go & rt_d[p].undef_read;
				RT_STALL[p] <= ACC_VALID[p] & stall_d[p];
			end
		end
	end

	// ***********************************************
	// Assertions
	// ***********************************************
	sequence s_req0(logic [1:0] sp);
		ACC_VALID[0] && !stall_d[0] && ACC_SPACE[1:0] == sp;
	endsequence

	sequence s_prog_hi0;
		s_req0(mmd_pkg::MMD_SP_PROG) ##0 ACC_ADDR[`MMD_HALF_BIT];
	endsequence

	a_io_goes_ext: assert property (@(posedge CLK) disable iff (SYS_RST)
		s_req0(mmd_pkg::MMD_SP_IO) |=> RT_TARGET[2:0] == mmd_pkg::MMD_TG_EXT)
		else $error("I/O access not routed external");

	a_overlay_low_prog: assert property (@(posedge CLK) disable iff (SYS_RST)
		s_req0(mmd_pkg::MMD_SP_PROG) ##0 !ACC_ADDR[`MMD_HALF_BIT] |=>
		RT_TARGET[2:0] == ($past(OVERLAY_ENABLE) ? mmd_pkg::MMD_TG_DUAL_ACCESS_RAM : mmd_pkg::MMD_TG_EXT))
		else $error("Lower program half ignores overlay");

	a_data_hi_gate: assert property (@(posedge CLK) disable iff (SYS_RST)
		s_req0(mmd_pkg::MMD_SP_DATA) ##0 ACC_ADDR[`MMD_HALF_BIT] |=>
		RT_TARGET[2:0] == ($past(DATA_SRAM_ENABLE) ? mmd_pkg::MMD_TG_SINGLE_ACCESS_RAM : mmd_pkg::MMD_TG_EXT))
		else $error("Upper data half ignores data-RAM enable");

	a_mp_mode_ext: assert property (@(posedge CLK) disable iff (SYS_RST)
		s_prog_hi0 ##0 MICROPROCESSOR_MODE |=>
		RT_TARGET[2:0] == mmd_pkg::MMD_TG_EXT && RT_EXT_PAGE[2] == 1'b0)
		else $error("Microprocessor mode upper half not external");

	a_far_page_alias: assert property (@(posedge CLK) disable iff (SYS_RST)
		s_prog_hi0 ##0 !MICROPROCESSOR_MODE ##0 ACC_PAGE[6:0] > `MMD_LAST_ONCHIP_PAGE |=>
		RT_TARGET[2:0] == mmd_pkg::MMD_TG_EXT && RT_EXT_PAGE[2:0] == {1'b1, $past(ACC_PAGE[1:0])})
		else $error("Far page not aliased onto pages 4-7");

	a_cpu_shared_wr: assert property (@(posedge CLK) disable iff (SYS_RST)
		RT_TARGET[2:0] == mmd_pkg::MMD_TG_SHARED && RT_WRITE[0] |-> $past(ACC_DMA[0]))
		else $error("CPU write reached shared RAM");

	a_ext_needs_xio: assert property (@(posedge CLK) disable iff (SYS_RST)
		RT_EXT_STROBE[0] |-> $past(xio_s) && RT_TARGET[2:0] == mmd_pkg::MMD_TG_EXT)
		else $error("External strobe without interface select");

	a_blocked_ext: assert property (@(posedge CLK) disable iff (SYS_RST)
		RT_TARGET[2:0] == mmd_pkg::MMD_TG_EXT && !$past(xio_s) |->
		!RT_WRITE[0] && !RT_EXT_STROBE[0] && (RT_DISCARD[0] || RT_UNDEF_READ[0]))
		else $error("Blocked external access not dropped");

	a_rom_window: assert property (@(posedge CLK) disable iff (SYS_RST)
		RT_TARGET[2:0] == mmd_pkg::MMD_TG_ROM |-> $past(rom_active) && $past(ACC_ADDR[15:0]) >= `MMD_ROM_BASE)
		else $error("ROM selected outside its window");

	a_strap_capture: assert property (@(posedge CLK)
		$fell(SYS_RST) |-> BOOT_ROM_ENABLE == $past(strap_s))
		else $error("ROM enable not taken from strap");

	a_sram_single: assert property (@(posedge CLK) disable iff (SYS_RST)
		RT_TARGET[2:0] == mmd_pkg::MMD_TG_SINGLE_ACCESS_RAM && RT_TARGET[5:3] == mmd_pkg::MMD_TG_SINGLE_ACCESS_RAM |->
		RT_BLOCK[3:0] != RT_BLOCK[7:4])
		else $error("Two accesses to one single-access block");

	a_shared_one_fetch: assert property (@(posedge CLK) disable iff (SYS_RST)
		RT_TARGET[2:0] == mmd_pkg::MMD_TG_SHARED |-> RT_TARGET[5:3] != mmd_pkg::MMD_TG_SHARED)
		else $error("Two shared fetches in one cycle");

	a_dual_access_ram_dual: assert property (@(posedge CLK) disable iff (SYS_RST)
		s_req0(mmd_pkg::MMD_SP_DATA) ##0 !ACC_ADDR[`MMD_HALF_BIT] ##0 ACC_VALID[1]
		&& ACC_SPACE[3:2] == mmd_pkg::MMD_SP_DATA && !ACC_ADDR[16+`MMD_HALF_BIT] |=>
		RT_VALID[1:0] == 2'h3 && !RT_STALL[1])
		else $error("Dual-access RAM refused a second access");

endmodule

`default_nettype wire

/* tb/mmd_ext_bus_model.sv */
`default_nettype none

module mmd_ext_bus_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] strobe,
	output int count
);
	timeunit 1ns;
	timeprecision 1ps;
	// ***********************************************
	// External bus cycles seen
	// ***********************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			count <= 0;
		end else begin
			count <= count + int'(strobe[0]) + int'(strobe[1]);
		end
	end
endmodule

`default_nettype wire

/* tb/test_mmd_decoder.sv */
`default_nettype none

module test_mmd_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0] DA = mmd_pkg::MMD_TG_DUAL_ACCESS_RAM;
	localparam logic [2:0] SA = mmd_pkg::MMD_TG_SINGLE_ACCESS_RAM;
	localparam logic [2:0] SH = mmd_pkg::MMD_TG_SHARED;
	localparam logic [2:0] RO = mmd_pkg::MMD_TG_ROM;
	localparam logic [2:0] EX = mmd_pkg::MMD_TG_EXT;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ovl = 1'b0, dsr = 1'b0, mpm = 1'b0, external_interface_select = 1'b0, strap = 1'b1, gwr = 1'b0;
	logic [15:0] gdat = 16'h0000;
	logic [1:0] vld = 2'h0, wr = 2'h0, dma = 2'h0;
	logic [3:0] spc = 4'h0;
	logic [31:0] adr = 32'h0;
	logic [13:0] pg = 14'h0;
	logic rom_en, sub_b;
	logic [1:0] r_vld, r_wr, r_stb, r_dis, r_und, r_own, r_stl;
	logic [5:0] r_tg, r_pg;
	logic [7:0] r_blk;
	logic [25:0] r_ofs;
	int ext_count;
	int mismatches = 0;
	int checks = 0;
	always #20 clk = ~clk;
	mmd_decoder #(.SUBSYS_B(1'b0), .PORTS(2)) i_dut (.CLK(clk), .SYS_RST(rst), .OVERLAY_ENABLE(ovl),
		.DATA_SRAM_ENABLE(dsr), .MICROPROCESSOR_MODE(mpm), .EXTERNAL_INTERFACE_SELECT(external_interface_select),
		.ROM_STRAP_PIN(strap), .GPIO_ROM_WR(gwr), .GPIO_WDATA(gdat), .ACC_VALID(vld), .ACC_SPACE(spc),
		.ACC_WRITE(wr), .ACC_DMA(dma), .ACC_ADDR(adr), .ACC_PAGE(pg), .BOOT_ROM_ENABLE(rom_en),
		.RT_VALID(r_vld), .RT_TARGET(r_tg), .RT_BLOCK(r_blk), .RT_OFFSET(r_ofs), .RT_EXT_PAGE(r_pg),
		.RT_WRITE(r_wr), .RT_EXT_STROBE(r_stb), .RT_DISCARD(r_dis), .RT_UNDEF_READ(r_und),
		.RT_OWNER_B(r_own), .RT_STALL(r_stl), .RT_SUBSYS_B(sub_b));
	mmd_ext_bus_model i_ext (.clk(clk), .rst(rst), .strobe(r_stb), .count(ext_count));
	// ***********************************************
	// Access and compare tasks
	// ***********************************************
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// Port 0 request; flags are {strobe, discard, undefined read, write}
	task automatic go(input logic [1:0] s, input logic w, input logic d, input logic [15:0] a,
		input logic [6:0] p, input logic [2:0] t, input logic [3:0] f);
		vld[0] = 1'b1;
		spc[1:0] = s;
		wr[0] = w;
		dma[0] = d;
		adr[15:0] = a;
		pg[6:0] = p;
		@(posedge clk);
		#1;
		chk("target", {13'h0, r_tg[2:0]}, {13'h0, t});
		chk("flags", {12'h0, r_stb[0], r_dis[0], r_und[0], r_wr[0]}, {12'h0, f});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	initial begin
		#100000;
		mismatches++;
		tally_and_finish();
	end
	// ***********************************************
	// Tests
	// ***********************************************
	initial begin
		settle();
		rst = 1'b0;
		chk("rom enable", {15'h0, rom_en}, 16'h0001);
		chk("subsystem", {15'h0, sub_b}, 16'h0000);
		external_interface_select = 1'b1;
		settle();
		$display("test reset done");
		go(2'h1, 1'b0, 1'b0, 16'h2000, 7'h00, DA, 4'h0);
		go(2'h1, 1'b0, 1'b0, 16'h8000, 7'h00, EX, 4'h8);
		dsr = 1'b1;
		go(2'h1, 1'b1, 1'b0, 16'ha005, 7'h00, SA, 4'h1);
		chk("block", {12'h0, r_blk[3:0]}, 16'h0001);
		chk("offset", {3'h0, r_ofs[12:0]}, 16'h0005);
		$display("test data done");
		go(2'h0, 1'b0, 1'b0, 16'h1000, 7'h00, EX, 4'h8);
		ovl = 1'b1;
		go(2'h0, 1'b0, 1'b0, 16'h1000, 7'h00, DA, 4'h0);
		go(2'h0, 1'b0, 1'b0, 16'hc000, 7'h02, SH, 4'h0);
		chk("block", {12'h0, r_blk[3:0]}, 16'h000a);
		chk("owner", {15'h0, r_own[0]}, 16'h0001);
		go(2'h0, 1'b0, 1'b0, 16'hc000, 7'h01, SH, 4'h0);
		chk("owner", {15'h0, r_own[0]}, 16'h0000);
		go(2'h0, 1'b0, 1'b0, 16'h8000, 7'h05, EX, 4'h8);
		chk("page", {13'h0, r_pg[2:0]}, 16'h0005);
		go(2'h0, 1'b0, 1'b0, 16'h8000, 7'h09, EX, 4'h8);
		chk("page", {13'h0, r_pg[2:0]}, 16'h0005);
		mpm = 1'b1;
		go(2'h0, 1'b0, 1'b0, 16'hc000, 7'h06, EX, 4'h8);
		chk("page", {13'h0, r_pg[2:0]}, 16'h0002);
		mpm = 1'b0;
		go(2'h0, 1'b1, 1'b0, 16'hc000, 7'h00, SH, 4'h4);
		go(2'h0, 1'b1, 1'b1, 16'hc000, 7'h00, SH, 4'h1);
		$display("test program done");
		go(2'h0, 1'b0, 1'b0, 16'he123, 7'h00, RO, 4'h0);
		chk("offset", {3'h0, r_ofs[12:0]}, 16'h0123);
		gwr = 1'b1;
		@(posedge clk);
		#1;
		gwr = 1'b0;
		chk("rom enable", {15'h0, rom_en}, 16'h0000);
		go(2'h0, 1'b0, 1'b0, 16'he123, 7'h00, SH, 4'h0);
		$display("test rom done");
		go(2'h2, 1'b0, 1'b0, 16'h0010, 7'h00, EX, 4'h8);
		vld[0] = 1'b0;
		external_interface_select = 1'b0;
		settle();
		chk("bus cycles", ext_count[15:0], 16'h0006);
		go(2'h2, 1'b0, 1'b0, 16'h0010, 7'h00, EX, 4'h2);
		go(2'h2, 1'b1, 1'b0, 16'h0010, 7'h00, EX, 4'h4);
		$display("test external done");
		spc[3:2] = 2'h0;
		adr[31:16] = 16'h8000;
		pg[13:7] = 7'h01;
		vld[1] = 1'b1;
		go(2'h0, 1'b0, 1'b0, 16'hc000, 7'h00, SH, 4'h0);
		chk("stall", {14'h0, r_stl}, 16'h0002);
		chk("valid", {14'h0, r_vld}, 16'h0001);
		vld = 2'h0;
		settle();
		chk("idle", {14'h0, r_vld}, 16'h0000);
		$display("test conflict done");
		spc[3:2] = 2'h1;
		adr[31:16] = 16'h2001;
		vld[1] = 1'b1;
		go(2'h1, 1'b0, 1'b0, 16'h2000, 7'h00, DA, 4'h0);
		chk("valid", {14'h0, r_vld}, 16'h0003);
		chk("target b", {13'h0, r_tg[5:3]}, {13'h0, DA});
		adr[31:16] = 16'ha100;
		go(2'h1, 1'b0, 1'b0, 16'ha000, 7'h00, SA, 4'h0);
		chk("stall", {14'h0, r_stl}, 16'h0002);
		adr[31:16] = 16'hc000;
		go(2'h1, 1'b0, 1'b0, 16'ha000, 7'h00, SA, 4'h0);
		chk("stall", {14'h0, r_stl}, 16'h0000);
		chk("target b", {13'h0, r_tg[5:3]}, {13'h0, SA});
		chk("block b", {12'h0, r_blk[7:4]}, 16'h0002);
		vld = 2'h0;
		$display("test dual port done");
		gdat = 16'h0080;
		gwr = 1'b1;
		@(posedge clk);
		#1;
		gwr = 1'b0;
		chk("rom enable", {15'h0, rom_en}, 16'h0001);
		go(2'h0, 1'b0, 1'b0, 16'he123, 7'h00, SH, 4'h0);
		vld = 2'h0;
		strap = 1'b0;
		rst = 1'b1;
		settle();
		rst = 1'b0;
		chk("rom enable", {15'h0, rom_en}, 16'h0000);
		chk("reset valid", {14'h0, r_vld}, 16'h0000);
		$display("test strap done");
		tally_and_finish();
	end
endmodule

`default_nettype wire
